/* File: rtl/tf_dev_framer.sv */
// device end: control word, rtp and oam framer with ahb-lite registers
// Operation
// - l2tpv3 over ipv6 uses next header 0x73
// - software loss flag copied into l bit
// - r bit from per-bundle remote failure
// - m field from defect modifier setting
// - cas fragmentation codes 00 01 10 11
// - length only below 64, not udp
// - per-bundle sequence, random start, wraps
// - hdlc sequence: zero, wrap, skip zero
// - oam query increments, reply echoes sequence
// - rtp version 2, other flags zero
// - rtp sequence equals control word sequence
// - payload type from dynamic range
// - absolute timestamp ticks every 125 us
// - differential timestamp from common reference
// - ssrc chosen randomly by software
// - receive nibble 0001 diverted as oam
// - udp oam uses reserved oam identifier
// - oam carries l r m, bundle ids
// - oam type 0 query, 8 reply
// - oam codes validate or mismatch
// - service word zero or aal1 counts
// - oam timestamps only when measuring delay
`include "tf_params.svh"
`timescale 1ns/10ps
`default_nettype none
module tf_dev_framer #(
	parameter int NB = 4 // bundles
) (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        tdm_frame, // 8 khz frame sync of the tdm port
	input  wire logic        cmn_tick,  // common reference tick
	tf_link_if.dev           lk
);
	import tf_pkg::*;
	localparam int BW = (NB > 1) ? $clog2(NB) : 1;
	// ****************************************
	// elaboration check
	// ****************************************
	// command bit 2 is the oam flag, so the bundle field may use two bits at most
	if (NB < 1 || NB > 4) begin : g_chk
		$error("tf_dev_framer: NB must be 1 to 4");
	end
	// ****************************************
	// registers and state
	// ****************************************
	logic [31:0]   ctrl_q;            // control bits
	logic [NB-1:0] rbit_q, hdlc_q;    // per bundle r bit and hdlc flag
	logic [6:0]    pt_q;              // rtp payload type
	logic [31:0]   ssrc_q, bids_q;    // ssrc, oam bundle ids
	logic [15:0]   oamid_q, svc_q;    // oam identifier, service word
	logic          ap_wr_q;           // write data phase pending
	logic [7:0]    ap_addr_q;         // latched address
	logic          go_q;              // command pulse
	logic [31:0]   cmd_q;             // latched command
	logic [15:0]   lfsr_q;            // free running random source
	logic [15:0]   seq_q [NB];        // per bundle sequence
	logic [NB-1:0] seeded_q;          // bundle has sent a data packet
	logic [15:0]   oseq_q, cseq_q;    // oam sequence, current sequence
	logic [31:0]   rts_q, ots_q;      // rtp and oam timestamps
	logic [11:0]   pre_q;             // oam timestamp prescaler
	tf_txst_t      st_q;              // transmit state
	logic [2:0]    wi_q;              // word index in state
	logic [5:0]    nw_q, pw_q;        // payload words, payload counter
	logic [2:0]    rx_i_q;            // receive word index
	logic          rx_oam_q;          // receiving an oam packet
	logic [15:0]   rx_seq_q, rep_seq_q;
	logic          rx_l_q, rx_r_q, rep_got_q;
	logic [7:0]    rep_code_q, vccv_q;
	logic          busy;
	logic [BW-1:0] cb;                // bundle of the command
	logic [15:0]   seq_d;
	logic [8:0]    tot;
	logic [5:0]    len_d;
	logic [31:0]   rd_d;
	wire ap = hsel & htrans[1] & hready;
	wire [1:0] mfld = ctrl_q[`TF_C_M_LO+:2];
	assign busy = (st_q != TX_IDLE);
	assign cb   = cmd_q[BW-1:0];
	// ****************************************
	// ahb-lite slave
	// ****************************************
	// address phase capture, zero wait states
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ap_wr_q   <= 1'b0;
			ap_addr_q <= 8'h00;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			ap_wr_q   <= ap & hwrite;
			ap_addr_q <= haddr[7:0];
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end
	// read mux, unmapped reads give zero
	always_comb begin
		unique case (haddr[7:0])
			`TF_A_CTRL:   rd_d = ctrl_q;
			`TF_A_RBIT:   rd_d = {16'h0000, 16'(hdlc_q) << 8 | 16'(rbit_q)};
			`TF_A_PT:     rd_d = {25'h0000000, pt_q};
			`TF_A_SSRC:   rd_d = ssrc_q;
			`TF_A_CMD:    rd_d = cmd_q;
			`TF_A_BIDS:   rd_d = bids_q;
			`TF_A_OAMID:  rd_d = {16'h0000, oamid_q};
			`TF_A_SVC:    rd_d = {16'h0000, svc_q};
			`TF_A_STAT:   rd_d = {rep_seq_q, rep_code_q, 6'h00, rep_got_q, busy};
			`TF_A_RXSTAT: rd_d = {vccv_q, 6'h00, rx_r_q, rx_l_q, rx_seq_q};
			default:      rd_d = 32'h0000_0000;
		endcase
	end
	// read data registered in the address phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) hrdata <= 32'h0000_0000;
		else if (ap && !hwrite) hrdata <= rd_d;
	end
	// configuration writes in the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_q  <= 32'h0000_0000;
			rbit_q  <= '0;
			hdlc_q  <= '0;
			pt_q    <= `TF_PT_DYN_LO;
			ssrc_q  <= 32'h0000_0000;
			bids_q  <= 32'h0000_0000;
			oamid_q <= 16'hFFFF;
			svc_q   <= 16'h0000;
		end else if (ap_wr_q) begin
			unique case (ap_addr_q)
				`TF_A_CTRL: ctrl_q <= hwdata;
				`TF_A_RBIT: begin
					rbit_q <= hwdata[NB-1:0];
					hdlc_q <= hwdata[8+:NB];
				end
				// values outside the dynamic range are refused
				`TF_A_PT:    if (hwdata[6:5] == 2'b11) pt_q <= hwdata[6:0];
				`TF_A_SSRC:  ssrc_q <= hwdata;
				`TF_A_BIDS:  bids_q <= hwdata;
				`TF_A_OAMID: oamid_q <= hwdata[15:0];
				`TF_A_SVC:   svc_q <= hwdata[15:0];
				default:     ;
			endcase
		end
	end
	// command write starts a packet when idle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			go_q  <= 1'b0;
			cmd_q <= 32'h0000_0000;
		end else begin
			go_q <= ap_wr_q && ap_addr_q == `TF_A_CMD && !busy && !go_q;
			if (ap_wr_q && ap_addr_q == `TF_A_CMD && !busy && !go_q) cmd_q <= hwdata;
		end
	end
	// ****************************************
	// sequence numbers and timestamps
	// ****************************************
	// random start value source
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) lfsr_q <= `TF_LFSR_SEED;
		else lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
	end
	// next data sequence for the commanded bundle
	always_comb begin
		seq_d = seeded_q[cb] ? seq_q[cb] + 16'h0001 : lfsr_q;
		if (hdlc_q[cb]) begin
			unique case (tf_hseq_t'(ctrl_q[`TF_C_HM_LO+:2]))
				HS_ZERO: seq_d = 16'h0000;
				HS_SKIP: if (seq_d == 16'h0000) seq_d = 16'h0001;
				default: ;
			endcase
		end
	end
	// per bundle counters advance on each data packet
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			seeded_q <= '0;
			oseq_q   <= 16'h0000;
			cseq_q   <= 16'h0000;
			for (int i = 0; i < NB; i++) seq_q[i] <= 16'h0000;
		end else if (go_q) begin
			if (cmd_q[2]) begin
				oseq_q <= oseq_q + 16'h0001;
				cseq_q <= oseq_q + 16'h0001;
			end else begin
				seq_q[cb]    <= seq_d;
				seeded_q[cb] <= 1'b1;
				cseq_q       <= seq_d;
			end
		end
	end
	// rtp timestamp: tdm frames or common reference ticks
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) rts_q <= 32'h0000_0000;
		else if (ctrl_q[`TF_C_DIFF] ? cmn_tick : tdm_frame) rts_q <= rts_q + 32'h0000_0001;
	end
	// oam timestamp at 1 us or 100 us resolution
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pre_q <= 12'h000;
			ots_q <= 32'h0000_0000;
		end else if (pre_q >= (ctrl_q[`TF_C_FINE] ? 12'(`TF_FINE_CYC - 1) : 12'(`TF_CRSE_CYC - 1))) begin
			pre_q <= 12'h000;
			ots_q <= ots_q + 32'h0000_0001;
		end else pre_q <= pre_q + 12'h001;
	end
	// ****************************************
	// transmit sequencer
	// ****************************************
	// byte count of control word, payload and rtp header
	always_comb begin
		tot   = `TF_CW_BYTES + {1'b0, cmd_q[15:8]} + (ctrl_q[`TF_C_RTP] ? `TF_RTP_BYTES : 9'h000);
		len_d = (tot < `TF_LEN_LIMIT && !ctrl_q[`TF_C_UDP]) ? tot[5:0] : 6'h00;
	end
	// one word per cycle from command to end of packet
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_q         <= TX_IDLE;
			wi_q         <= 3'h0;
			nw_q         <= 6'h00;
			pw_q         <= 6'h00;
			lk.d2f_data  <= 32'h0000_0000;
			lk.d2f_valid <= 1'b0;
			lk.d2f_sop   <= 1'b0;
			lk.d2f_eop   <= 1'b0;
			lk.d2f_bid   <= 16'h0000;
			lk.d2f_nh    <= 8'h00;
		end else begin
			lk.d2f_valid <= 1'b0;
			lk.d2f_sop   <= 1'b0;
			lk.d2f_eop   <= 1'b0;
			wi_q         <= wi_q + 3'h1;
			unique case (st_q)
				TX_IDLE: begin
					wi_q <= 3'h0;
					nw_q <= (cmd_q[15:10] == 6'h00) ? 6'h01 : cmd_q[15:10] + 6'(cmd_q[9:8] != 2'b00);
					if (go_q) st_q <= TX_CW;
				end
				TX_CW: begin
					lk.d2f_valid <= 1'b1;
					lk.d2f_sop   <= 1'b1;
					lk.d2f_nh    <= ctrl_q[`TF_C_L2V6] ? `TF_NH_L2TP : `TF_NH_UDP;
					lk.d2f_bid   <= cmd_q[2] ? oamid_q : 16'(cb);
					// r follows the bundle under test; l and m come from the control register
					lk.d2f_data  <= {4'h0, ctrl_q[`TF_C_LOSS], rbit_q[cb], mfld,
						cmd_q[2] ? 2'b00 : (ctrl_q[`TF_C_CAS] ? cmd_q[4:3] : 2'b00),
						cmd_q[2] ? (ctrl_q[`TF_C_DELAY] ? `TF_OAM_LEN_TS : `TF_OAM_LEN) : len_d, cseq_q};
					wi_q <= 3'h0;
					pw_q <= 6'h00;
					st_q <= cmd_q[2] ? TX_OAM : (ctrl_q[`TF_C_RTP] ? TX_RTP : TX_PAY);
				end
				TX_RTP: begin
					lk.d2f_valid <= 1'b1;
					unique case (wi_q)
						3'h0:    lk.d2f_data <= {`TF_RTP_VER, 6'h00, 1'b0, pt_q, cseq_q};
						3'h1:    lk.d2f_data <= rts_q;
						default: lk.d2f_data <= ssrc_q;
					endcase
					if (wi_q == 3'h2) st_q <= TX_PAY;
				end
				TX_PAY: begin
					// stand-in payload: bundle and word count
					lk.d2f_valid <= 1'b1;
					lk.d2f_data  <= {16'(cb), 10'h000, pw_q};
					pw_q         <= pw_q + 6'h01;
					if (pw_q == nw_q - 6'h01) begin
						lk.d2f_eop <= 1'b1;
						st_q       <= TX_IDLE;
					end
				end
				TX_OAM: begin
					lk.d2f_valid <= 1'b1;
					unique case (wi_q)
						3'h0:    lk.d2f_data <= {`TF_MT_QUERY, 7'h00, cmd_q[16], svc_q};
						3'h1:    lk.d2f_data <= bids_q;
						3'h2:    lk.d2f_data <= ots_q;
						default: lk.d2f_data <= 32'h0000_0000;
					endcase
					if (wi_q == (ctrl_q[`TF_C_DELAY] ? 3'h4 : 3'h1)) begin
						lk.d2f_eop <= 1'b1;
						st_q       <= TX_IDLE;
					end
				end
				default: st_q <= TX_IDLE;
			endcase
		end
	end
	// ****************************************
	// receive classifier
	// ****************************************
	// oam replies and in-band oam are split from data
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_i_q     <= 3'h0;
			rx_oam_q   <= 1'b0;
			rx_seq_q   <= 16'h0000;
			rx_l_q     <= 1'b0;
			rx_r_q     <= 1'b0;
			vccv_q     <= 8'h00;
			rep_seq_q  <= 16'h0000;
			rep_code_q <= 8'h00;
			rep_got_q  <= 1'b0;
		end else if (lk.f2d_valid) begin
			rx_i_q <= lk.f2d_sop ? 3'h1 : rx_i_q + 3'h1;
			if (lk.f2d_sop) begin
				rx_oam_q <= (lk.f2d_bid == oamid_q);
				if (lk.f2d_bid == oamid_q) rep_seq_q <= lk.f2d_data[15:0];
				else if (lk.f2d_data[31:28] == `TF_OAM_NIB) vccv_q <= vccv_q + 8'h01;
				else begin
					rx_seq_q <= lk.f2d_data[15:0];
					rx_l_q   <= lk.f2d_data[27];
					rx_r_q   <= lk.f2d_data[26];
				end
			end else if (rx_oam_q && rx_i_q == 3'h1 && lk.f2d_data[31:24] == `TF_MT_REPLY) begin
				rep_code_q <= lk.f2d_data[23:16];
				rep_got_q  <= 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

/* File: rtl/tf_params.svh */
// constants for the pseudowire control word, rtp and oam framer
`ifndef TF_PARAMS_SVH
`define TF_PARAMS_SVH
// ****************************************
// protocol values
// ****************************************
`define TF_NH_L2TP     8'h73
`define TF_NH_UDP      8'h11
`define TF_OAM_NIB     4'h1
`define TF_MT_QUERY    8'h00
`define TF_MT_REPLY    8'h08
`define TF_MC_ZERO     8'h00
`define TF_MC_ONE      8'h01
`define TF_RTP_VER     2'h2
`define TF_PT_DYN_LO   7'h60
`define TF_LEN_LIMIT   9'h040
`define TF_CW_BYTES    9'h004
`define TF_RTP_BYTES   9'h00C
`define TF_OAM_LEN     6'h10
`define TF_OAM_LEN_TS  6'h1C
`define TF_LFSR_SEED   16'hACE1
// ****************************************
// timing
// ****************************************
`define TF_CLK_NS      40
`define TF_RES_FINE_NS 1000
`define TF_RES_CRSE_NS 100000
`define TF_FINE_CYC    (`TF_RES_FINE_NS / `TF_CLK_NS)
`define TF_CRSE_CYC    (`TF_RES_CRSE_NS / `TF_CLK_NS)
// ****************************************
// register offsets
// ****************************************
`define TF_A_CTRL      8'h00
`define TF_A_RBIT      8'h04
`define TF_A_PT        8'h08
`define TF_A_SSRC      8'h0C
`define TF_A_CMD       8'h10
`define TF_A_BIDS      8'h14
`define TF_A_OAMID     8'h18
`define TF_A_SVC       8'h1C
`define TF_A_STAT      8'h20
`define TF_A_RXSTAT    8'h24
// ****************************************
// control register fields
// ****************************************
`define TF_C_LOSS      0
`define TF_C_M_LO      1
`define TF_C_RTP       3
`define TF_C_DIFF      4
`define TF_C_UDP       5
`define TF_C_L2V6      6
`define TF_C_FINE      7
`define TF_C_DELAY     8
`define TF_C_HM_LO     9
`define TF_C_CAS       11
`endif

/* File: rtl/tf_pkg.sv */
// types shared by both ends of the framer link
package tf_pkg;
	// device transmit sequencer
	typedef enum logic [2:0] {
		TX_IDLE = 3'b000,
		TX_CW   = 3'b001,
		TX_RTP  = 3'b010,
		TX_PAY  = 3'b011,
		TX_OAM  = 3'b100
	} tf_txst_t;
	// far end reply sequencer
	typedef enum logic [1:0] {
		FR_IDLE = 2'b00,
		FR_CW   = 2'b01,
		FR_BODY = 2'b10
	} tf_frst_t;
	// hdlc sequence behaviour
	typedef enum logic [1:0] {
		HS_ZERO = 2'b00,
		HS_WRAP = 2'b01,
		HS_SKIP = 2'b10
	} tf_hseq_t;
endpackage

/* File: rtl/tf_link_if.sv */
// packet link between the framer and the remote gateway
`timescale 1ns/10ps
`default_nettype none
interface tf_link_if;
	logic [31:0] d2f_data;  // word towards the far end
	logic        d2f_valid; // word present
	logic        d2f_sop;   // first word of packet
	logic        d2f_eop;   // last word of packet
	logic [15:0] d2f_bid;   // bundle identifier, valid with sop
	logic [7:0]  d2f_nh;    // ip next header, valid with sop
	logic [31:0] f2d_data;  // word towards the device
	logic        f2d_valid;
	logic        f2d_sop;
	logic        f2d_eop;
	logic [15:0] f2d_bid;
	modport dev (output d2f_data, d2f_valid, d2f_sop, d2f_eop, d2f_bid, d2f_nh,
		input f2d_data, f2d_valid, f2d_sop, f2d_eop, f2d_bid);
	modport far (input d2f_data, d2f_valid, d2f_sop, d2f_eop, d2f_bid, d2f_nh,
		output f2d_data, f2d_valid, f2d_sop, f2d_eop, f2d_bid);
endinterface
`default_nettype wire

/* File: rtl/tf_far_gateway.sv */
// far end: remote gateway answering oam queries and watching data arrival
`include "tf_params.svh"
`timescale 1ns/10ps
`default_nettype none
module tf_far_gateway #(
	parameter int TW = 8 // width of the missing packet threshold
) (
	input  wire logic          hclk,
	input  wire logic          hresetn,
	tf_link_if.far             lk,
	input  wire logic [15:0]   cfg_oam_id,   // reserved oam identifier
	input  wire logic          cfg_loss,     // local loss flag
	input  wire logic [1:0]    cfg_m,        // defect modifier
	input  wire logic [15:0]   cfg_svc,      // own service word
	input  wire logic [TW-1:0] cfg_miss_thr, // missing packets before r
	input  wire logic          slot_tick,    // one expected packet period
	input  wire logic          cfg_fine,     // 1 us timestamps, else 100 us
	output logic               remote_fail,  // r bit sent back
	output logic [15:0]        last_seq,     // last data sequence seen
	output logic [7:0]         replies       // replies sent
);
	import tf_pkg::*;
	if (TW < 1 || TW > 16) begin : g_chk
		$error("tf_far_gateway: TW must be 1 to 16");
	end
	// ****************************************
	// state
	// ****************************************
	logic [2:0]    ri_q;         // receive word index
	logic          qry_q;        // packet is an oam query
	logic [15:0]   qseq_q;       // query sequence
	logic [7:0]    qcode_q;      // query code
	logic          qbad_q;       // service word mismatch
	logic [31:0]   qbid_q, qts_q, rts_q, ts_q;
	logic          qts_v_q;      // query carried timestamps
	logic [11:0]   pre_q;        // timestamp prescaler
	logic [TW-1:0] miss_q;       // consecutive missed slots
	logic          seen_q;       // packet seen in this slot
	tf_frst_t      st_q;
	logic [2:0]    wi_q;
	wire rx_data = lk.d2f_valid & lk.d2f_sop & (lk.d2f_bid != cfg_oam_id);
	// ****************************************
	// local timestamp
	// ****************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pre_q <= 12'h000;
			ts_q  <= 32'h0000_0000;
		end else if (pre_q >= (cfg_fine ? 12'(`TF_FINE_CYC - 1) : 12'(`TF_CRSE_CYC - 1))) begin
			pre_q <= 12'h000;
			ts_q  <= ts_q + 32'h0000_0001;
		end else pre_q <= pre_q + 12'h001;
	end
	// ****************************************
	// remote failure watch
	// ****************************************
	// arrival clears at once; a slot end with nothing counts a miss
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			miss_q      <= '0;
			seen_q      <= 1'b0;
			remote_fail <= 1'b0;
			last_seq    <= 16'h0000;
		end else if (rx_data) begin
			miss_q      <= '0;
			seen_q      <= 1'b1;
			remote_fail <= 1'b0;
			last_seq    <= lk.d2f_data[15:0];
		end else if (slot_tick) begin
			seen_q <= 1'b0;
			if (!seen_q && miss_q != '1) miss_q <= miss_q + 1'b1;
			if (!seen_q && miss_q + 1'b1 >= cfg_miss_thr) remote_fail <= 1'b1;
		end
	end
	// ****************************************
	// query capture
	// ****************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ri_q    <= 3'h0;
			qry_q   <= 1'b0;
			qseq_q  <= 16'h0000;
			qcode_q <= 8'h00;
			qbad_q  <= 1'b0;
			qbid_q  <= 32'h0000_0000;
			qts_q   <= 32'h0000_0000;
			rts_q   <= 32'h0000_0000;
			qts_v_q <= 1'b0;
		end else if (lk.d2f_valid) begin
			ri_q <= lk.d2f_sop ? 3'h1 : ri_q + 3'h1;
			if (lk.d2f_sop) begin
				qry_q   <= (lk.d2f_bid == cfg_oam_id);
				qseq_q  <= lk.d2f_data[15:0];
				qts_v_q <= (lk.d2f_data[21:16] == `TF_OAM_LEN_TS);
				rts_q   <= ts_q;
			end else begin
				unique case (ri_q)
					3'h1: begin
						qcode_q <= lk.d2f_data[23:16];
						qbad_q  <= (lk.d2f_data[15:0] != cfg_svc);
						qry_q   <= qry_q && lk.d2f_data[31:24] == `TF_MT_QUERY;
					end
					3'h2:    qbid_q <= lk.d2f_data;
					3'h3:    qts_q <= lk.d2f_data;
					default: ;
				endcase
			end
		end
	end
	// ****************************************
	// reply sequencer
	// ****************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_q         <= FR_IDLE;
			wi_q         <= 3'h0;
			replies      <= 8'h00;
			lk.f2d_data  <= 32'h0000_0000;
			lk.f2d_valid <= 1'b0;
			lk.f2d_sop   <= 1'b0;
			lk.f2d_eop   <= 1'b0;
			lk.f2d_bid   <= 16'h0000;
		end else begin
			lk.f2d_valid <= 1'b0;
			lk.f2d_sop   <= 1'b0;
			lk.f2d_eop   <= 1'b0;
			wi_q         <= wi_q + 3'h1;
			unique case (st_q)
				FR_IDLE: begin
					wi_q <= 3'h0;
					if (lk.d2f_valid && lk.d2f_eop && qry_q && !lk.d2f_sop) st_q <= FR_CW;
				end
				FR_CW: begin
					lk.f2d_valid <= 1'b1;
					lk.f2d_sop   <= 1'b1;
					lk.f2d_bid   <= cfg_oam_id;
					// sequence echoed unchanged
					lk.f2d_data  <= {4'h0, cfg_loss, remote_fail, cfg_m, 2'b00,
						qts_v_q ? `TF_OAM_LEN_TS : `TF_OAM_LEN, qseq_q};
					wi_q <= 3'h0;
					st_q <= FR_BODY;
				end
				FR_BODY: begin
					lk.f2d_valid <= 1'b1;
					unique case (wi_q)
						// mismatch only reported when validation was asked
						3'h0: lk.f2d_data <= {`TF_MT_REPLY,
							(qcode_q == `TF_MC_ZERO && qbad_q) ? `TF_MC_ONE : `TF_MC_ZERO, cfg_svc};
						3'h1:    lk.f2d_data <= {qbid_q[15:0], qbid_q[31:16]};
						3'h2:    lk.f2d_data <= qts_q;
						3'h3:    lk.f2d_data <= rts_q;
						default: lk.f2d_data <= ts_q;
					endcase
					if (wi_q == (qts_v_q ? 3'h4 : 3'h1)) begin
						lk.f2d_eop <= 1'b1;
						replies    <= replies + 8'h01;
						st_q       <= FR_IDLE;
					end
				end
				default: st_q <= FR_IDLE;
			endcase
		end
	end
endmodule
`default_nettype wire

/* File: testbench/tf_sva.sv */
// assertions on the link between framer and far gateway
`timescale 1ns/10ps
`default_nettype none
module tf_sva #(parameter logic [15:0] OAM_ID = 16'hFFFF) (
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic [31:0] d2f_data,
	input wire logic        d2f_valid,
	input wire logic        d2f_sop,
	input wire logic        d2f_eop,
	input wire logic [15:0] d2f_bid,
	input wire logic [7:0]  d2f_nh,
	input wire logic [31:0] f2d_data,
	input wire logic        f2d_valid,
	input wire logic        f2d_sop,
	input wire logic [15:0] f2d_bid
);
	logic        oam_q, typ0_q, seen_q; // query in flight, any query seen
	logic [15:0] qseq_q;                // sequence of the last query
	logic [3:0]  idx_q;                 // word index inside a packet
	wire         sop = d2f_valid && d2f_sop;
	wire         qend = d2f_valid && d2f_eop && oam_q && typ0_q;
	// follow device packets word by word
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			{oam_q, typ0_q, seen_q, qseq_q, idx_q} <= '0;
		end else if (sop) begin
			oam_q <= d2f_bid == OAM_ID;
			idx_q <= 4'h1;
			seen_q <= seen_q || d2f_bid == OAM_ID;
			if (d2f_bid == OAM_ID) qseq_q <= d2f_data[15:0];
		end else if (d2f_valid) begin
			idx_q <= idx_q + 4'h1;
			if (idx_q == 4'h1) typ0_q <= d2f_data[31:24] == 8'h00;
		end
	end
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	chk_nh_code: assert property (sop |-> d2f_nh inside {8'h73, 8'h11})
		else $error("bad next header");
	chk_cw_top: assert property (sop |-> d2f_data[31:28] == 4'h0)
		else $error("control word top nibble set");
	chk_len_data: assert property (sop && d2f_bid != OAM_ID |-> d2f_data[21:16] == 6'h0 || d2f_data[21:16] >= 6'h4)
		else $error("data length out of range");
	chk_len_oam: assert property (sop && d2f_bid == OAM_ID |-> d2f_data[21:16] inside {6'h10, 6'h1C})
		else $error("oam length wrong");
	chk_query_step: assert property (sop && d2f_bid == OAM_ID && seen_q |-> d2f_data[15:0] == qseq_q + 16'h1)
		else $error("query sequence not incremented");
	chk_reply_start: assert property (qend |-> ##2 f2d_valid && f2d_sop && f2d_bid == OAM_ID)
		else $error("reply missing or late");
	chk_reply_seq: assert property (qend |-> ##2 f2d_data[15:0] == qseq_q)
		else $error("reply sequence changed");
	chk_reply_type: assert property (qend |-> ##3 f2d_valid && f2d_data[31:24] == 8'h08)
		else $error("reply type wrong");
endmodule
`default_nettype wire

/* File: testbench/tdmop_cw_rtp_oam_framer_tb.sv */
// self-checking bench for the framer and far gateway pair
`include "tf_params.svh"
`timescale 1ns/10ps
`default_nettype none
module tdmop_cw_rtp_oam_framer_tb;
	logic        hclk = 1'b0, hresetn = 1'b0, tick = 1'b0, hsel, hwrite, loss, fine, slot, rd_ph, rtp_on;
	logic [1:0]  htrans, m;
	logic [31:0] haddr, hwdata, hrdata, ssrc, rnd = 32'h6518EECB;
	logic        hreadyout, hresp, rfail;
	logic [15:0] svc, lseq, cseq, pseq;
	logic [7:0]  reps;
	logic [32:0] mk, ev[$], em[$];     // expected link words and masks
	logic [31:0] rq[$];                // expected read data
	int          num_errors = 0, n_checks = 0, widx;
	tf_link_if lk ();
	tf_dev_framer tf_dev_framer_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .tdm_frame(tick), .cmn_tick(tick), .lk(lk.dev));
	tf_far_gateway tf_far_gateway_inst (.hclk(hclk), .hresetn(hresetn), .lk(lk.far), .cfg_oam_id(16'hFFFF),
		.cfg_loss(loss), .cfg_m(m), .cfg_svc(svc), .cfg_miss_thr(8'h03), .slot_tick(slot), .cfg_fine(fine),
		.remote_fail(rfail), .last_seq(lseq), .replies(reps));
	tf_sva tf_sva_inst (.hclk(hclk), .hresetn(hresetn), .d2f_data(lk.d2f_data), .d2f_valid(lk.d2f_valid),
		.d2f_sop(lk.d2f_sop), .d2f_eop(lk.d2f_eop), .d2f_bid(lk.d2f_bid), .d2f_nh(lk.d2f_nh),
		.f2d_data(lk.f2d_data), .f2d_valid(lk.f2d_valid), .f2d_sop(lk.f2d_sop), .f2d_bid(lk.f2d_bid));
	always #20 hclk = ~hclk;
	always @(posedge hclk) tick <= !tick;
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		return s ^ (s << 5);
	endfunction
	task automatic check(input string nm, input logic [32:0] seen, exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// one single ahb-lite transfer, address phase then data phase
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		{hsel, htrans, hwrite, haddr} <= {1'b1, 2'b10, wr, 24'h0, a};
		do @(posedge hclk); while (!hreadyout);
		{hsel, htrans, hwdata, rd_ph} <= {1'b0, 2'b00, d, !wr};
		do @(posedge hclk); while (!hreadyout);
		rd_ph <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		rq.push_back(e);
		bus(1'b0, a, 32'h0);
	endtask
	task automatic exp(input logic [32:0] v, k);
		ev.push_back(v & k);
		em.push_back(k);
	endtask
	task automatic wait_eop();
		repeat (300) begin
			@(posedge hclk);
			if (lk.d2f_valid && lk.d2f_eop) break;
		end
		repeat (12) @(posedge hclk);
	endtask
	task automatic cfg(input logic r, d);
		rnd = xs(rnd);
		{loss, m, fine} <= rnd[3:0];
		rtp_on = r;
		bus(1'b1, `TF_A_CTRL, {20'h0, 3'h4, d, rnd[0], 1'b1, r, r, r, rnd[2:1], rnd[3]});
	endtask
	// data packet on bundle 1
	task automatic pkt(input logic [1:0] frg, input logic [7:0] nb, input logic rb);
		logic [5:0] ln;
		ln = (!rtp_on && nb < 8'd60) ? 6'(nb + 8'd4) : 6'h0;
		exp({5'h0, loss, rb, m, frg, ln, 16'h0}, 33'h1_FFFF_0000);
		if (rtp_on) begin
			exp({3'h2, 7'h0, 7'h65, 16'h0}, 33'h1_FFFF_0000);
			exp(33'h0, 33'h1_0000_0000);
			exp({1'b0, ssrc}, '1);
		end
		for (int i = 1; i <= (nb + 3) / 4; i++) exp({i == (nb + 3) / 4, 32'h0}, 33'h1_0000_0000);
		bus(1'b1, `TF_A_CMD, {16'h0, nb, 3'h0, frg, 3'h1});
		wait_eop();
	endtask
	// connectivity query and its reply, timestamps only when measuring delay
	task automatic oam(input logic qc, rc, dl, input logic [15:0] sq);
		exp({5'h0, loss, 1'b1, m, 2'h0, dl ? `TF_OAM_LEN_TS : `TF_OAM_LEN, sq}, '1);
		exp({16'h0, qc, 16'h0818}, '1);
		exp({!dl, 32'h0001_0002}, '1);
		if (dl) begin
			exp(33'h0, 33'h1_0000_0000);
			exp(33'h0, '1);
			exp({1'b1, 32'h0}, '1);
		end
		bus(1'b1, `TF_A_CMD, {15'h0, qc, 13'h0, 3'h5});
		wait_eop();
		rd(`TF_A_STAT, {sq, 7'h0, rc, 8'h2});
	endtask
	// compare each result against the oldest note
	always @(posedge hclk) begin
		if (rd_ph) check("read data", {hresp, hrdata}, {1'b0, rq.pop_front()});
		if (lk.d2f_valid) begin
			if (lk.d2f_sop) cseq = lk.d2f_data[15:0];
			if (lk.d2f_sop) check("next header", lk.d2f_nh, `TF_NH_L2TP);
			if (widx == 1 && rtp_on) check("rtp sequence", lk.d2f_data[15:0], cseq);
			mk = em.pop_front();
			check("link word", {lk.d2f_eop, lk.d2f_data} & mk, ev.pop_front());
			widx = lk.d2f_sop ? 1 : widx + 1;
		end
	end
	initial begin
		#400000;
		num_errors++;
		give_verdict();
	end
	initial begin
		{hsel, htrans, hwrite, haddr, hwdata, rd_ph, slot, loss, m, fine, svc, rtp_on} = '0;
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rd(`TF_A_CTRL, 32'h0);
		rd(`TF_A_OAMID, 32'hFFFF);
		bus(1'b1, 8'h30, 32'hFFFF_FFFF);
		rd(8'h30, 32'h0);
		rd(`TF_A_PT, 32'h60);
		bus(1'b1, `TF_A_PT, 32'h65);
		bus(1'b1, `TF_A_PT, 32'h15);
		rd(`TF_A_PT, 32'h65);
		ssrc = xs(rnd);
		bus(1'b1, `TF_A_SSRC, ssrc);
		for (int f = 0; f < 4; f++) begin
			cfg(f[1], 1'b0);
			if (f == 3) bus(1'b1, `TF_A_RBIT, 32'h2);
			pkt(f[1:0], 8'd59 + 8'(f[0]), f == 3);
			if (f > 0) check("sequence step", cseq, pseq + 16'h1);
			pseq = cseq;
			check("far sequence", lseq, cseq);
		end
		repeat (8) begin
			slot <= !slot;
			@(posedge hclk);
		end
		@(negedge hclk);
		check("remote fail", rfail, 1'b1);
		bus(1'b1, `TF_A_RBIT, 32'h202);
		pkt(2'h0, 8'd8, 1'b1);
		check("remote clear", rfail, 1'b0);
		check("hdlc zero", cseq, 33'h0);
		bus(1'b1, `TF_A_SVC, 32'h0818);
		bus(1'b1, `TF_A_BIDS, 32'h0001_0002);
		for (int i = 0; i < 3; i++) begin
			svc <= (i == 0) ? 16'h0818 : 16'h0817;
			cfg(1'b0, i != 2);
			oam(i == 2, i == 1, i != 2, 16'(i + 1));
		end
		check("words left", 33'(ev.size()), 33'h0);
		check("replies", reps, 33'h3);
		give_verdict();
	end
endmodule
`default_nettype wire
